//--- rtl/fmr_params.svh
// constants for the fan monitor readout and status bank
// Behaviour
// - fan1 low count byte readable, read-only
// - fan2 count: high byte first, then low
// - period counted in 100 kHz reference ticks
// - temp high byte: sign, then 2^6..2^0
// - remote low byte: three fraction bits, zeros
// - local low byte uses same layout
// - status read clears alarm bits 6..0, not bit7
// - persisting fault sets alarm bit again
// - bit7 nvm corrupt, cleared only write+reset
// - bit6 diode fault, never drives alert
// - bit5 die above local high setpoint
// - bit4 local above local overtemp setpoint
// - bits3,2 remote above high, overtemp setpoints
// - bits1,0 fan over threshold, stopped, overflow
// - fan1 high byte holds count bits 15..8
`ifndef FMR_PARAMS_SVH
`define FMR_PARAMS_SVH

`define FMR_ADDR_FAN1_HI 8'h52
`define FMR_ADDR_FAN1_LO 8'h53
`define FMR_ADDR_FAN2_HI 8'h54
`define FMR_ADDR_FAN2_LO 8'h55
`define FMR_ADDR_RTEMP_HI 8'h56
`define FMR_ADDR_RTEMP_LO 8'h57
`define FMR_ADDR_LTEMP_HI 8'h58
`define FMR_ADDR_LTEMP_LO 8'h59
`define FMR_ADDR_STATUS 8'h5a

`define FMR_BIT_NVM 7
`define FMR_BIT_DIODE 6
`define FMR_BIT_LHIGH 5
`define FMR_BIT_LOT 4
`define FMR_BIT_RHIGH 3
`define FMR_BIT_ROT 2
`define FMR_BIT_FAN2 1
`define FMR_BIT_FAN1 0

`define FMR_RESET_BYTE 8'h00
`define FMR_CLK_HZ 125000000
`define FMR_REF_HZ 100000
`define FMR_REF_DIV (`FMR_CLK_HZ / `FMR_REF_HZ)

`endif

//--- rtl/fmr_pkg.sv
// types shared by the fan monitor readout bank
package fmr_pkg;
  typedef struct packed {
    logic valid;
    logic [10:0] value;
  } fmr_temp_s;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
  } fmr_rd_s;
endpackage : fmr_pkg

//--- rtl/fmr_readout.sv
// fan monitor readout and status register bank
`timescale 1ns/1ns
`include "fmr_params.svh"

module fmr_readout #(
  parameter int CNT_W = 16,
  parameter int REF_DIV = `FMR_REF_DIV
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // host register read port from the serial slave
  input fmr_pkg::fmr_rd_s rd_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // tachometer pins and threshold
  input wire logic fan1_speed_input_i,
  input wire logic fan2_speed_input_i,
  input wire logic [CNT_W-1:0] count_threshold_i,
  // temperature samples (signed eighths) and setpoints (signed whole degrees)
  input fmr_pkg::fmr_temp_s remote_temp_i,
  input fmr_pkg::fmr_temp_s local_temp_i,
  input wire logic [7:0] local_high_sp_i,
  input wire logic [7:0] local_ot_sp_i,
  input wire logic [7:0] remote_high_sp_i,
  input wire logic [7:0] remote_ot_sp_i,
  // fault sources
  input wire logic diode_fault_i,
  input wire logic nvm_corrupt_i,
  input wire logic nvm_write_ok_i,
  input wire logic soft_reset_i,
  // temperature alert
  output logic alert_o
);
  import fmr_pkg::*;

  // ---------------- reference tick ----------------
  logic [15:0] ref_cnt_r, ref_cnt_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    ref_cnt_nxt = ref_cnt_r + 16'h0001;
    if (ref_cnt_r == 16'(REF_DIV - 1)) begin
      ref_cnt_nxt = 16'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      ref_cnt_r <= ref_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ---------------- tachometer period counters ----------------
  logic [1:0] tach_in;
  logic [CNT_W-1:0] fan_count [2];
  logic [1:0] fan_ovf;
  assign tach_in = {fan2_speed_input_i, fan1_speed_input_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tach
      logic prev_r, prev_nxt;
      logic ovf_r, ovf_nxt;
      logic [CNT_W-1:0] acc_r, acc_nxt;
      logic [CNT_W-1:0] cnt_r, cnt_nxt;
      logic sat;
      assign sat = &acc_r;

      always_comb begin
        prev_nxt = tach_in[g];
        acc_nxt = acc_r;
        ovf_nxt = ovf_r;
        cnt_nxt = cnt_r;
        if (tick_r && !sat) begin
          acc_nxt = acc_r + CNT_W'(1);
        end
        // a stopped fan saturates and reports full scale
        if (tick_r && sat) begin
          ovf_nxt = 1'b1;
          cnt_nxt = '1;
        end
        // a tick in the edge cycle still belongs to the ending period
        // whole count published at once
        if (tach_in[g] && !prev_r) begin
          cnt_nxt = (ovf_r || sat) ? '1 : acc_nxt;
          ovf_nxt = 1'b0;
          acc_nxt = '0;
        end
      end

      always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          prev_r <= 1'b0;
          ovf_r <= 1'b0;
          acc_r <= '0;
          cnt_r <= '0;
        end else begin
          prev_r <= prev_nxt;
          ovf_r <= ovf_nxt;
          acc_r <= acc_nxt;
          cnt_r <= cnt_nxt;
        end
      end

      assign fan_count[g] = cnt_r;
      assign fan_ovf[g] = ovf_r;
    end
  endgenerate

  // ---------------- helpers ----------------
  function automatic logic temp_above(input logic [10:0] t, input logic [7:0] sp);
    temp_above = $signed(t) > $signed({sp, 3'b000});
  endfunction : temp_above

  function automatic logic is_rd(input fmr_rd_s r, input logic [7:0] a);
    is_rd = r.en && (r.addr == a);
  endfunction : is_rd

  // ---------------- readout registers ----------------
  logic [10:0] rtemp_r, rtemp_nxt;
  logic [10:0] ltemp_r, ltemp_nxt;
  logic [7:0] status_r, status_nxt;
  logic nvm_wrok_r, nvm_wrok_nxt;
  logic [7:0] shadow_r [4];
  logic [7:0] shadow_nxt [4];
  logic [3:0] hold_r, hold_nxt;
  logic [7:0] rd_data_nxt;
  logic alert_nxt;
  logic [7:0] cond;
  logic [7:0] hi_byte [4];
  logic [7:0] lo_byte [4];
  logic [7:0] hi_addr [4];
  logic [7:0] lo_addr [4];

  assign hi_addr = '{`FMR_ADDR_FAN1_HI, `FMR_ADDR_FAN2_HI, `FMR_ADDR_RTEMP_HI,
                     `FMR_ADDR_LTEMP_HI};
  assign lo_addr = '{`FMR_ADDR_FAN1_LO, `FMR_ADDR_FAN2_LO, `FMR_ADDR_RTEMP_LO,
                     `FMR_ADDR_LTEMP_LO};
  // sign and integer bits in high byte
  assign hi_byte = '{fan_count[0][15:8], fan_count[1][15:8], rtemp_r[10:3], ltemp_r[10:3]};
  // fraction bits on top, zeros below
  assign lo_byte = '{fan_count[0][7:0], fan_count[1][7:0], {rtemp_r[2:0], 5'b0_0000},
                     {ltemp_r[2:0], 5'b0_0000}};

  always_comb begin
    cond = 8'h00;
    cond[`FMR_BIT_DIODE] = diode_fault_i;
    cond[`FMR_BIT_LHIGH] = temp_above(ltemp_r, local_high_sp_i);
    cond[`FMR_BIT_LOT] = temp_above(ltemp_r, local_ot_sp_i);
    cond[`FMR_BIT_RHIGH] = temp_above(rtemp_r, remote_high_sp_i);
    cond[`FMR_BIT_ROT] = temp_above(rtemp_r, remote_ot_sp_i);
    cond[`FMR_BIT_FAN2] = (fan_count[1] > count_threshold_i) || fan_ovf[1];
    cond[`FMR_BIT_FAN1] = (fan_count[0] > count_threshold_i) || fan_ovf[0];
  end

  always_comb begin
    rtemp_nxt = remote_temp_i.valid ? remote_temp_i.value : rtemp_r;
    ltemp_nxt = local_temp_i.valid ? local_temp_i.value : ltemp_r;
    // read clears, condition sets; set wins
    status_nxt[6:0] = cond[6:0] |
      (status_r[6:0] & {7{!is_rd(rd_i, `FMR_ADDR_STATUS)}});
    // corrupt flag ignores reads; clear needs write then reset
    nvm_wrok_nxt = (nvm_wrok_r || nvm_write_ok_i) && !nvm_corrupt_i;
    status_nxt[`FMR_BIT_NVM] = status_r[`FMR_BIT_NVM];
    if (soft_reset_i && nvm_wrok_r) begin
      status_nxt[`FMR_BIT_NVM] = 1'b0;
      nvm_wrok_nxt = 1'b0;
    end
    if (nvm_corrupt_i) begin
      status_nxt[`FMR_BIT_NVM] = 1'b1;
    end
    // unmapped or write addresses read zero
    rd_data_nxt = `FMR_RESET_BYTE;
    if (is_rd(rd_i, `FMR_ADDR_STATUS)) begin
      rd_data_nxt = status_r;
    end
    hold_nxt = hold_r;
    shadow_nxt = shadow_r;
    for (int i = 0; i < 4; i++) begin
      // high read freezes the paired low byte
      if (is_rd(rd_i, hi_addr[i])) begin
        rd_data_nxt = hi_byte[i];
        shadow_nxt[i] = lo_byte[i];
        hold_nxt[i] = 1'b1;
      end
      if (is_rd(rd_i, lo_addr[i])) begin
        rd_data_nxt = hold_r[i] ? shadow_r[i] : lo_byte[i];
        hold_nxt[i] = 1'b0;
      end
    end
    // only temperature alarms reach the alert pin
    alert_nxt = |status_nxt[`FMR_BIT_LHIGH:`FMR_BIT_ROT];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rtemp_r <= 11'h000;
      ltemp_r <= 11'h000;
      status_r <= `FMR_RESET_BYTE;
      nvm_wrok_r <= 1'b0;
      hold_r <= 4'h0;
      shadow_r <= '{default: `FMR_RESET_BYTE};
      rd_data_o <= `FMR_RESET_BYTE;
      rd_valid_o <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      rtemp_r <= rtemp_nxt;
      ltemp_r <= ltemp_nxt;
      status_r <= status_nxt;
      nvm_wrok_r <= nvm_wrok_nxt;
      hold_r <= hold_nxt;
      shadow_r <= shadow_nxt;
      rd_data_o <= rd_data_nxt;
      rd_valid_o <= rd_i.en;
      alert_o <= alert_nxt;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  logic status_rd;
  assign status_rd = is_rd(rd_i, `FMR_ADDR_STATUS);

  chk_read_latency: assert property (
    rd_i.en |=> rd_valid_o ##1 (!rd_valid_o || $past(rd_i.en)))
    else $error("read answer not one cycle after request");

  chk_status_clear: assert property (
    status_rd && (cond[6:0] == 7'h00) |=> status_r[6:0] == 7'h00)
    else $error("alarm bits survived a status read");

  chk_alarm_reset: assert property (
    cond[`FMR_BIT_FAN1] |=> status_r[`FMR_BIT_FAN1])
    else $error("persisting fan fault not flagged");

  chk_nvm_sticky: assert property (
    (status_r[`FMR_BIT_NVM] && !soft_reset_i) |=> status_r[`FMR_BIT_NVM])
    else $error("corrupt flag cleared without reset");

  chk_lhigh_flag: assert property (
    $signed(ltemp_r) > $signed({local_high_sp_i, 3'b000}) |=> status_r[`FMR_BIT_LHIGH])
    else $error("local high alarm missing");

  chk_low_zero: assert property (
    is_rd(rd_i, `FMR_ADDR_RTEMP_LO) |=> rd_data_o[4:0] == 5'b0_0000)
    else $error("remote low byte padding not zero");

  chk_diode_alert: assert property (
    (status_r[5:2] == 4'h0) |-> !alert_o)
    else $error("alert raised without temperature alarm");

  chk_pair_atomic: assert property (
    is_rd(rd_i, `FMR_ADDR_FAN2_HI) ##5 is_rd(rd_i, `FMR_ADDR_FAN2_LO)
      |=> rd_data_o == $past(g_tach[1].cnt_r[7:0], 6))
    else $error("fan2 low byte from a different sample");

  chk_ref_tick: assert property (
    tick_r |=> !tick_r [*2])
    else $error("reference tick too frequent");

  chk_fan1_count: assert property (
    is_rd(rd_i, `FMR_ADDR_FAN1_HI) |=> rd_data_o == $past(fan_count[0][15:8]))
    else $error("fan1 high byte wrong");

  chk_fan1_low: assert property (
    is_rd(rd_i, `FMR_ADDR_FAN1_LO) && !hold_r[0] |=> rd_data_o == $past(fan_count[0][7:0]))
    else $error("fan1 low byte wrong");

  chk_fan2_high: assert property (
    is_rd(rd_i, `FMR_ADDR_FAN2_HI) |=> rd_data_o == $past(fan_count[1][15:8]))
    else $error("fan2 high byte wrong");

  chk_temp_sign: assert property (
    is_rd(rd_i, `FMR_ADDR_LTEMP_HI) |=> rd_data_o[7] == $past(ltemp_r[10]))
    else $error("local sign bit not in bit 7");

  chk_local_zero: assert property (
    is_rd(rd_i, `FMR_ADDR_LTEMP_LO) |=> rd_data_o[4:0] == 5'b0_0000)
    else $error("local low byte padding not zero");

  chk_lot_flag: assert property (
    temp_above(ltemp_r, local_ot_sp_i) |=> status_r[`FMR_BIT_LOT])
    else $error("local overtemp alarm missing");

  chk_rhigh_flag: assert property (
    temp_above(rtemp_r, remote_high_sp_i) |=> status_r[`FMR_BIT_RHIGH])
    else $error("remote high alarm missing");

  chk_rot_flag: assert property (
    temp_above(rtemp_r, remote_ot_sp_i) |=> status_r[`FMR_BIT_ROT])
    else $error("remote overtemp alarm missing");

  chk_fan2_alarm: assert property (
    (fan_count[1] > count_threshold_i) |=> status_r[`FMR_BIT_FAN2])
    else $error("fan2 over threshold not flagged");

  chk_nvm_set: assert property (
    nvm_corrupt_i |=> status_r[`FMR_BIT_NVM])
    else $error("corrupt flag not set");

  chk_unmapped_zero: assert property (
    rd_i.en && (rd_i.addr < `FMR_ADDR_FAN1_HI || rd_i.addr > `FMR_ADDR_STATUS)
      |=> rd_data_o == `FMR_RESET_BYTE)
    else $error("unmapped address read not zero");

  // reference for the pair check: remote low byte seen at the last high read
  logic [7:0] snap_lo_r, snap_lo_nxt;
  logic snap_pend_r, snap_pend_nxt;

  always_comb begin
    snap_lo_nxt = snap_lo_r;
    snap_pend_nxt = snap_pend_r;
    if (is_rd(rd_i, `FMR_ADDR_RTEMP_HI)) begin
      snap_lo_nxt = {rtemp_r[2:0], 5'b0_0000};
      snap_pend_nxt = 1'b1;
    end
    if (is_rd(rd_i, `FMR_ADDR_RTEMP_LO)) begin
      snap_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      snap_lo_r <= 8'h00;
      snap_pend_r <= 1'b0;
    end else begin
      snap_lo_r <= snap_lo_nxt;
      snap_pend_r <= snap_pend_nxt;
    end
  end

  chk_snap_pair: assert property (
    is_rd(rd_i, `FMR_ADDR_RTEMP_LO) && snap_pend_r |=> rd_data_o == snap_lo_r)
    else $error("remote low byte not from the high read sample");

  cov_status_read: cover property (status_rd && status_r[6:0] != 7'h00);
  cov_fan_overflow: cover property (fan_ovf[0]);
  cov_pair_read: cover property (is_rd(rd_i, `FMR_ADDR_RTEMP_HI) ##1
    is_rd(rd_i, `FMR_ADDR_RTEMP_LO));
  cov_nvm_clear: cover property (status_r[`FMR_BIT_NVM] ##1 !status_r[`FMR_BIT_NVM]);
  cov_over_temp: cover property (status_r[`FMR_BIT_LOT] && alert_o);
endmodule : fmr_readout

//--- testbench/fmr_host_model.sv
// host side model issuing register reads and capturing answers
`timescale 1ns/1ns

module fmr_host_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // bench command
  input wire logic go_i,
  input wire logic [7:0] addr_i,
  output logic [7:0] data_o,
  output logic done_o,
  // register read port
  output fmr_pkg::fmr_rd_s rd_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i
);
  import fmr_pkg::*;

  // idle address inverts each cycle so a stale value never looks valid
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_o <= '0;
      data_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      rd_o.en <= go_i;
      rd_o.addr <= go_i ? addr_i : ~rd_o.addr;
      done_o <= rd_valid_i;
      if (rd_valid_i) begin
        data_o <= rd_data_i;
      end
    end
  end
endmodule : fmr_host_model

//--- testbench/tb_top.sv
// self-checking bench for the fan monitor readout bank
`timescale 1ns/1ns

module tb_top;
  import fmr_pkg::*;

  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] hdata, rd_data, d;
  logic hdone, rd_valid, alert;
  fmr_rd_s rd;
  logic tach_on = 1'b0;
  logic [9:0] tc = 10'h000;
  logic [15:0] thr = 16'hffff;
  fmr_temp_s rtemp = '0;
  fmr_temp_s ltemp = '0;
  logic [7:0] sp_lh = 8'h7f, sp_lo = 8'h7f, sp_rh = 8'h7f, sp_ro = 8'h7f;
  logic diode = 1'b0, corrupt = 1'b0, wok = 1'b0, srst = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // short reference divider keeps tach counts small
  fmr_readout #(.CNT_W(16), .REF_DIV(4)) uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rd_i(rd), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .fan1_speed_input_i(tc[4]), .fan2_speed_input_i(tc[9]),
    .count_threshold_i(thr), .remote_temp_i(rtemp), .local_temp_i(ltemp),
    .local_high_sp_i(sp_lh), .local_ot_sp_i(sp_lo), .remote_high_sp_i(sp_rh),
    .remote_ot_sp_i(sp_ro), .diode_fault_i(diode), .nvm_corrupt_i(corrupt),
    .nvm_write_ok_i(wok), .soft_reset_i(srst), .alert_o(alert));

  fmr_host_model host (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go), .addr_i(addr), .data_o(hdata),
    .done_o(hdone), .rd_o(rd), .rd_data_i(rd_data), .rd_valid_i(rd_valid));

  // fan1_speed_input period 32 clocks = 8 ticks, fan2_speed_input period 1024 clocks = 256 ticks
  always @(posedge clk_sys_i) begin
    if (tach_on) tc <= tc + 10'h001;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic rdreg(input logic [7:0] a, output logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    go <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    go <= 1'b0;
    // sampled at the edge: hdone and hdata still show the settled cycle
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hdone !== 1'b1 && n < 10);
    if (n >= 10) cmp(8'hxx, 8'h00, "no read answer");
    v = hdata;
  endtask : rdreg

  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rdreg(a, v);
    cmp(v & m, e, $sformatf("reg %h", a));
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick

  initial begin
    tick(16);
    rst_i <= 1'b0;
    for (int a = 8'h52; a < 8'h5a; a++) chk(a[7:0], 8'hff, 8'h00);
    chk(8'h5a, 8'hfc, 8'h00);
    chk(8'h60, 8'hff, 8'h00);
    rtemp <= '{1'b1, 11'h0cd};
    ltemp <= '{1'b1, 11'h7ef};
    tick(1);
    rtemp.valid <= 1'b0;
    ltemp.valid <= 1'b0;
    tick(4);
    chk(8'h56, 8'hff, 8'h19);
    chk(8'h57, 8'hff, 8'ha0);
    chk(8'h58, 8'hff, 8'hfd);
    chk(8'h59, 8'hff, 8'he0);
    tach_on <= 1'b1;
    tick(3000);
    chk(8'h52, 8'hff, 8'h00);
    chk(8'h53, 8'hff, 8'h08);
    chk(8'h53, 8'hff, 8'h08);
    chk(8'h54, 8'hff, 8'h01);
    chk(8'h55, 8'hff, 8'h00);
    thr <= 16'h0005;
    tick(2100);
    chk(8'h5a, 8'h03, 8'h03);
    thr <= 16'hffff;
    tick(2100);
    rdreg(8'h5a, d);
    chk(8'h5a, 8'h03, 8'h00);
    // remote 205 vs 200 and 208, local -17 vs -24 and -16, in eighths
    sp_rh <= 8'h19;
    sp_ro <= 8'h1a;
    sp_lh <= 8'hfd;
    sp_lo <= 8'hfe;
    tick(4);
    cmp({7'h00, alert}, 8'h01, "alert on");
    chk(8'h5a, 8'hfc, 8'h28);
    sp_rh <= 8'h7f;
    sp_lh <= 8'h7f;
    tick(4);
    chk(8'h5a, 8'hfc, 8'h28);
    chk(8'h5a, 8'hfc, 8'h00);
    cmp({7'h00, alert}, 8'h00, "alert off");
    sp_rh <= 8'h19;
    tick(4);
    chk(8'h5a, 8'hfc, 8'h08);
    sp_rh <= 8'h7f;
    tick(4);
    rdreg(8'h5a, d);
    // local -17 vs -24, remote 205 vs 200: both overtemp alarms
    sp_lo <= 8'hfd;
    sp_ro <= 8'h19;
    tick(4);
    cmp({7'h00, alert}, 8'h01, "alert ot");
    chk(8'h5a, 8'hfc, 8'h14);
    sp_lo <= 8'hfe;
    sp_ro <= 8'h1a;
    tick(4);
    rdreg(8'h5a, d);
    diode <= 1'b1;
    tick(4);
    cmp({7'h00, alert}, 8'h00, "diode alert");
    chk(8'h5a, 8'hfc, 8'h40);
    diode <= 1'b0;
    tick(2);
    rdreg(8'h5a, d);
    corrupt <= 1'b1;
    tick(1);
    corrupt <= 1'b0;
    tick(2);
    chk(8'h5a, 8'hfc, 8'h80);
    chk(8'h5a, 8'hfc, 8'h80);
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    tick(2);
    chk(8'h5a, 8'hfc, 8'h80);
    wok <= 1'b1;
    tick(1);
    wok <= 1'b0;
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    tick(2);
    chk(8'h5a, 8'hfc, 8'h00);
    // a new sample between high and low read must not split the pair
    chk(8'h56, 8'hff, 8'h19);
    rtemp <= '{1'b1, 11'h0ff};
    tick(1);
    rtemp.valid <= 1'b0;
    tick(2);
    chk(8'h57, 8'hff, 8'ha0);
    chk(8'h57, 8'hff, 8'he0);
    chk(8'h56, 8'hff, 8'h1f);
    summarize();
  end
endmodule : tb_top
